// *** rtl/seg_lcd_pkg.sv ***
/*
 * Shared constants of the segment display controller: register map,
 * field positions, reset values, mode codes and divider counts.
 * Assumes a 32-bit APB with one register per aligned word.
 */
package seg_lcd_pkg;

    // ************************************************************
    // Register map (printed offsets are indices; byte addr = 4*idx)
    // ************************************************************
    localparam logic [7:0]  SEG_DATA_FIRST_IDX   = 8'h40;
    localparam logic [7:0]  SEG_DATA_LAST_IDX    = 8'h49;
    localparam logic [7:0]  SEG_PAIR_11_12_IDX   = 8'h45;
    localparam logic [7:0]  DISPLAY_CONTROL_IDX  = 8'h54;
    localparam logic [7:0]  CLOCK_SELECT_IDX     = 8'h60;
    localparam int          SEG_PAIRS            = 16;
    localparam int          SEG_COUNT            = 32;
    localparam int          COM_COUNT            = 4;

    // ************************************************************
    // Display control fields
    // ************************************************************
    localparam int          FRAME_DIV_SEL_MSB    = 7;
    localparam int          FRAME_DIV_SEL_LSB    = 6;
    localparam int          DISPLAY_ENABLE_BIT   = 5;
    localparam int          BIAS_SELECT_BIT      = 3;
    localparam int          DUTY_SELECT_MSB      = 2;
    localparam int          DUTY_SELECT_LSB      = 1;
    localparam int          PUMP_ENABLE_BIT      = 0;
    localparam logic [7:0]  DISPLAY_CONTROL_MASK = 8'hEF;
    localparam logic [7:0]  DISPLAY_CONTROL_RST  = 8'h00;

    // ************************************************************
    // Clock select fields
    // ************************************************************
    localparam int          MAIN_SRC_SEL_BIT     = 0;
    localparam int          QUARTER_DIV_SEL_BIT  = 1;
    localparam int          EXT_HALF_SEL_BIT     = 3;
    localparam int          TICK_SRC_SEL_BIT     = 5;
    localparam logic [7:0]  CLOCK_SELECT_MASK    = 8'h2B;
    localparam logic [7:0]  CLOCK_SELECT_RST     = 8'h00;

    // ************************************************************
    // Divider counts
    // ************************************************************
    localparam logic [9:0]  SYS_TICK_DIV         = 10'd1000;
    localparam logic [9:0]  EXT_TICK_DIV         = 10'd32;
    localparam logic [9:0]  QUARTER_DIV          = 10'd4;
    localparam logic [9:0]  HALF_DIV             = 10'd2;
    localparam logic [5:0]  FRAME_DIV_8          = 6'd7;
    localparam logic [5:0]  FRAME_DIV_16         = 6'd15;
    localparam logic [5:0]  FRAME_DIV_32         = 6'd31;
    localparam logic [5:0]  FRAME_DIV_64         = 6'd63;

    // Duty modes
    typedef enum logic [1:0] {
        DUTY_STATIC  = 2'h0,
        DUTY_HALF    = 2'h1,
        DUTY_THIRD   = 2'h2,
        DUTY_QUARTER = 2'h3
    } duty_type;

endpackage

// *** rtl/pulse_divider.sv ***
/*
 * Enable-pulse divider: emits one pulse every 'ratio' input pulses.
 * Assumes ratio is held stable and is at least one.
 */
`timescale 1ns/100ps
`default_nettype none

module pulse_divider (
    input  wire logic       mclk,
    input  wire logic       reset_n,
    input  wire logic       run,
    input  wire logic       in_pulse,
    input  wire logic [9:0] ratio,
    output logic            out_pulse
);

    logic [9:0] count_reg;

    // ************************************************************
    // Counter
    // ************************************************************
    // Cleared while stopped so each start begins a fresh period
    always_ff @(posedge mclk) begin
        if (!reset_n || !run) begin
            count_reg <= 10'h000;
            out_pulse <= 1'b0;
        end else if (in_pulse) begin
            if (count_reg >= ratio - 10'd1) begin
                count_reg <= 10'h000;
                out_pulse <= 1'b1;
            end else begin
                count_reg <= count_reg + 10'd1;
                out_pulse <= 1'b0;
            end
        end else begin
            out_pulse <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// *** rtl/segment_memory.sv ***
/*
 * Segment data store: sixteen bytes, one per segment pair.
 * Registered read port; contents are not reset.
 */
`timescale 1ns/100ps
`default_nettype none

module segment_memory (
    input  wire logic       mclk,
    input  wire logic       wr_en,
    input  wire logic [3:0] wr_addr,
    input  wire logic [7:0] wr_data,
    input  wire logic [3:0] rd_addr,
    output logic      [7:0] rd_data,
    output logic    [127:0] all_data
);

    logic [7:0] mem_reg [0:15];

    // ************************************************************
    // Storage
    // ************************************************************
    // No reset: power-on contents are undefined
    always_ff @(posedge mclk) begin
        if (wr_en) begin
            mem_reg[wr_addr] <= wr_data;
        end
        rd_data <= mem_reg[rd_addr];
    end

    // Flat view for the scan logic
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            all_data[i*8 +: 8] = mem_reg[i];
        end
    end

endmodule

`default_nettype wire

// *** rtl/segment_lcd_driver_control.sv ***
/*
 * Segment display driver control: APB registers, clock source tree
 * as enable pulses, frame divider, common scan and segment outputs.
 * Assumes internal and external oscillators arrive as asynchronous
 * square waves sampled by mclk, both slower than mclk/4.
 */
// The APB slave port was chosen for this implementation.
// How it works
// - High nibble of pair 11/12 register is segment 12, bit n with common n+1.
// - Low nibble of that register is segment 11, bit 0 common 1, bit 3 common 4.
// - Control bits 7-6 hold the two-bit frame divider selector.
// - Selector 00,01,10,11 divides module tick by 8,16,32,64.
// - Control bit 5 enables driver and runs its clock; clear stops both.
// - Control bit 3 picks bias: 0 one-third, 1 one-half.
// - Control bits 2-1 pick duty: static, half, third, quarter.
// - Control bit 0 enables the bias charge pump.
// - Thirty-two segment outputs and four common outputs drive the panel.
// - System clock is main clock, or main clock over four when selected.
// - Main clock is internal osc, external osc, or external over two.
// - Module tick is system clock over 1000, or external osc over 32.
// - Only low common bits matching the duty are used.
// - Frame clock is module tick over the divider, only while enabled.
// - Segment data registers sit at 40H..49H (the code decodes 40H..4FH, 16 pairs), odd segment in low nibble.
`timescale 1ns/100ps
`default_nettype none

module segment_lcd_driver_control (
    input  wire logic        mclk,
    input  wire logic        reset_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic      [31:0] prdata,
    output logic             pslverr,
    input  wire logic        internal_osc_clk,
    input  wire logic        external_osc_clk,
    output logic      [31:0] segment_out,
    output logic       [3:0] common_out,
    output logic             pump_enable,
    output logic             bias_half,
    output logic             frame_clk
);

    // ************************************************************
    // Declarations
    // ************************************************************
    logic [7:0]   display_control_reg;
    logic [7:0]   clock_select_reg;
    logic [1:0]   int_sync_reg;
    logic [1:0]   ext_sync_reg;
    logic         int_last_reg;
    logic         ext_last_reg;
    logic         int_edge;
    logic         ext_edge;
    logic         main_pulse;
    logic         ext_half_pulse;
    logic         sys_pulse;
    logic         quarter_pulse;
    logic         sys_tick_pulse;
    logic         ext_tick_pulse;
    logic         tick_pulse;
    logic [5:0]   frame_count_reg;
    logic [5:0]   frame_limit;
    logic [1:0]   phase_reg;
    logic [1:0]   phase_last;
    logic         display_enable;
    logic [1:0]   duty_select;
    logic [9:0]   word_index;
    logic         access;
    logic         hit_seg;
    logic         hit_ctl;
    logic         hit_clk;
    logic         rd_pending_reg;
    logic [7:0]   mem_rd_data;
    logic [127:0] seg_data;

    assign display_enable = display_control_reg[seg_lcd_pkg::DISPLAY_ENABLE_BIT];
    assign duty_select    = display_control_reg[seg_lcd_pkg::DUTY_SELECT_MSB:seg_lcd_pkg::DUTY_SELECT_LSB];

    // ************************************************************
    // APB decode
    // ************************************************************
    // Offsets are word indices; low address bits must be zero
    assign word_index = paddr[11:2];
    assign access     = psel && penable;
    // Whole 40H..4FH page decodes, so all 32 segment outputs have data behind them
    assign hit_seg    = (paddr[1:0] == 2'h0)
                        && (word_index[9:4] == {2'h0, seg_lcd_pkg::SEG_DATA_FIRST_IDX[7:4]});
    assign hit_ctl    = (paddr[1:0] == 2'h0) && (word_index == {2'h0, seg_lcd_pkg::DISPLAY_CONTROL_IDX});
    assign hit_clk    = (paddr[1:0] == 2'h0) && (word_index == {2'h0, seg_lcd_pkg::CLOCK_SELECT_IDX});

    // Segment reads take one extra wait state for the registered memory port
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            rd_pending_reg <= 1'b0;
        end else begin
            rd_pending_reg <= access && !pwrite && hit_seg && !rd_pending_reg;
        end
    end

    // Ready, read data and error, all registered
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (access && !pready) begin
            if (hit_seg && !pwrite) begin
                pready  <= rd_pending_reg;
                prdata  <= {24'h00_0000, mem_rd_data};
                pslverr <= 1'b0;
            end else begin
                pready  <= 1'b1;
                pslverr <= !(hit_seg || hit_ctl || hit_clk);
                if (hit_ctl) begin
                    prdata <= {24'h00_0000, display_control_reg};
                end else if (hit_clk) begin
                    prdata <= {24'h00_0000, clock_select_reg};
                end else begin
                    prdata <= 32'h0000_0000;
                end
            end
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // Control register; bit 4 is unimplemented and stays zero
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            display_control_reg <= seg_lcd_pkg::DISPLAY_CONTROL_RST;
        end else if (access && !pready && pwrite && hit_ctl) begin
            display_control_reg <= pwdata[7:0] & seg_lcd_pkg::DISPLAY_CONTROL_MASK;
        end
    end

    // Clock source selects
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            clock_select_reg <= seg_lcd_pkg::CLOCK_SELECT_RST;
        end else if (access && !pready && pwrite && hit_clk) begin
            clock_select_reg <= pwdata[7:0] & seg_lcd_pkg::CLOCK_SELECT_MASK;
        end
    end

    // Segment pair storage, 16 pairs; pair 11/12 is index 45H
    segment_memory seg_mem (
        .mclk     (mclk),
        .wr_en    (access && !pready && pwrite && hit_seg),
        .wr_addr  (word_index[3:0]),
        .wr_data  (pwdata[7:0]),
        .rd_addr  (word_index[3:0]),
        .rd_data  (mem_rd_data),
        .all_data (seg_data)
    );

    // ************************************************************
    // Oscillator sampling
    // ************************************************************
    // Two flops each, edges taken only from the second
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            int_sync_reg <= 2'h0;
            ext_sync_reg <= 2'h0;
            int_last_reg <= 1'b0;
            ext_last_reg <= 1'b0;
        end else begin
            int_sync_reg <= {int_sync_reg[0], internal_osc_clk};
            ext_sync_reg <= {ext_sync_reg[0], external_osc_clk};
            int_last_reg <= int_sync_reg[1];
            ext_last_reg <= ext_sync_reg[1];
        end
    end

    assign int_edge = int_sync_reg[1] && !int_last_reg;
    assign ext_edge = ext_sync_reg[1] && !ext_last_reg;

    // ************************************************************
    // Clock tree as enable pulses
    // ************************************************************
    pulse_divider ext_half_div (
        .mclk      (mclk),
        .reset_n   (reset_n),
        .run       (1'b1),
        .in_pulse  (ext_edge),
        .ratio     (seg_lcd_pkg::HALF_DIV),
        .out_pulse (ext_half_pulse)
    );

    // Main clock source choice
    assign main_pulse = !clock_select_reg[seg_lcd_pkg::MAIN_SRC_SEL_BIT] ? int_edge
                      : (clock_select_reg[seg_lcd_pkg::EXT_HALF_SEL_BIT] ? ext_half_pulse : ext_edge);

    pulse_divider quarter_div (
        .mclk      (mclk),
        .reset_n   (reset_n),
        .run       (1'b1),
        .in_pulse  (main_pulse),
        .ratio     (seg_lcd_pkg::QUARTER_DIV),
        .out_pulse (quarter_pulse)
    );

    assign sys_pulse = clock_select_reg[seg_lcd_pkg::QUARTER_DIV_SEL_BIT] ? quarter_pulse : main_pulse;

    pulse_divider sys_tick_div (
        .mclk      (mclk),
        .reset_n   (reset_n),
        .run       (1'b1),
        .in_pulse  (sys_pulse),
        .ratio     (seg_lcd_pkg::SYS_TICK_DIV),
        .out_pulse (sys_tick_pulse)
    );

    pulse_divider ext_tick_div (
        .mclk      (mclk),
        .reset_n   (reset_n),
        .run       (1'b1),
        .in_pulse  (ext_edge),
        .ratio     (seg_lcd_pkg::EXT_TICK_DIV),
        .out_pulse (ext_tick_pulse)
    );

    // Module tick source
    assign tick_pulse = clock_select_reg[seg_lcd_pkg::TICK_SRC_SEL_BIT] ? ext_tick_pulse : sys_tick_pulse;

    // ************************************************************
    // Frame divider
    // ************************************************************
    // Ascending code, ascending ratio
    always_comb begin
        unique case (display_control_reg[seg_lcd_pkg::FRAME_DIV_SEL_MSB:seg_lcd_pkg::FRAME_DIV_SEL_LSB])
            2'h0: begin
                frame_limit = seg_lcd_pkg::FRAME_DIV_8;
            end
            2'h1: begin
                frame_limit = seg_lcd_pkg::FRAME_DIV_16;
            end
            2'h2: begin
                frame_limit = seg_lcd_pkg::FRAME_DIV_32;
            end
            2'h3: begin
                frame_limit = seg_lcd_pkg::FRAME_DIV_64;
            end
        endcase
    end

    // Frame clock toggles each half period; halted when disabled
    always_ff @(posedge mclk) begin
        if (!reset_n || !display_enable) begin
            frame_count_reg <= 6'h00;
            frame_clk       <= 1'b0;
        end else if (tick_pulse) begin
            if (frame_count_reg >= frame_limit) begin
                frame_count_reg <= 6'h00;
                frame_clk       <= 1'b0;
            end else begin
                frame_count_reg <= frame_count_reg + 6'd1;
                frame_clk       <= (frame_count_reg + 6'd1) > (frame_limit >> 1);
            end
        end
    end

    // ************************************************************
    // Common scan
    // ************************************************************
    // Last active common follows the duty; wraps back to common 1
    assign phase_last = duty_select;

    always_ff @(posedge mclk) begin
        if (!reset_n || !display_enable) begin
            phase_reg <= 2'h0;
        end else if (tick_pulse && frame_count_reg >= frame_limit) begin
            phase_reg <= (phase_reg >= phase_last) ? 2'h0 : phase_reg + 2'd1;
        end
    end

    // Segment and common outputs; all low while disabled
    always_ff @(posedge mclk) begin
        if (!reset_n || !display_enable) begin
            segment_out <= 32'h0000_0000;
            common_out  <= 4'h0;
        end else begin
            common_out <= 4'h1 << phase_reg;
            for (int p = 0; p < seg_lcd_pkg::SEG_PAIRS; p++) begin
                // Odd segment low nibble, even segment high nibble
                segment_out[2*p]   <= seg_data[p*8 + 0 + phase_reg];
                segment_out[2*p+1] <= seg_data[p*8 + 4 + phase_reg];
            end
        end
    end

    // Bias and pump levels straight from control
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            pump_enable <= 1'b0;
            bias_half   <= 1'b0;
        end else begin
            pump_enable <= display_control_reg[seg_lcd_pkg::PUMP_ENABLE_BIT];
            bias_half   <= display_control_reg[seg_lcd_pkg::BIAS_SELECT_BIT];
        end
    end

endmodule

`default_nettype wire

// *** sim/seg_lcd_props.sv ***
/* Port assertions for the display control block.
   Assumes one clock domain, synchronous active-low reset. */
`timescale 1ns/100ps
`default_nettype none
module seg_lcd_props (
    input wire logic        mclk,
    input wire logic        reset_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic        internal_osc_clk,
    input wire logic        external_osc_clk,
    input wire logic [31:0] segment_out,
    input wire logic [3:0]  common_out,
    input wire logic        pump_enable,
    input wire logic        bias_half,
    input wire logic        frame_clk
);
    // ********
    // Shadows of software writes
    // ********
    logic [7:0] ctl_shadow;
    logic [7:0] pair_shadow;
    logic [3:0] settle;
    logic [3:0] duty_mask;
    logic [1:0] seg_exp;
    wire        done_wr = psel && penable && pready && pwrite;
    wire        ctl_wr  = done_wr && paddr[11:2] == {2'h0, seg_lcd_pkg::DISPLAY_CONTROL_IDX};
    wire        mapped  = paddr[1:0] == 2'h0 && (paddr[11:6] == 6'h04
                          || paddr[11:2] == {2'h0, seg_lcd_pkg::DISPLAY_CONTROL_IDX}
                          || paddr[11:2] == {2'h0, seg_lcd_pkg::CLOCK_SELECT_IDX});
    // Control copy; settle counts cycles since its last write
    always_ff @(posedge mclk) begin
        if (!reset_n) ctl_shadow <= 8'h00;
        else if (ctl_wr) ctl_shadow <= pwdata[7:0];
    end
    always_ff @(posedge mclk) begin
        if (!reset_n || ctl_wr) settle <= 4'h0;
        else if (settle != 4'hF) settle <= settle + 4'h1;
    end
    // Pair 11/12 copy; not reset, like the store itself
    always_ff @(posedge mclk) begin
        if (done_wr && paddr == 12'h114) pair_shadow <= pwdata[7:0];
    end
    // Commons allowed by the duty code
    always_comb begin
        case (ctl_shadow[2:1])
            2'h0: duty_mask = 4'h1;
            2'h1: duty_mask = 4'h3;
            2'h2: duty_mask = 4'h7;
            default: duty_mask = 4'hF;
        endcase
    end
    assign seg_exp = {|(pair_shadow[7:4] & common_out), |(pair_shadow[3:0] & common_out)};
    // ********
    // Properties
    // ********
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    sequence setup_s; psel && !penable; endsequence
    sequence answer_s; psel && penable && pready; endsequence
    sequence held_s; (common_out != 4'h0) [*4]; endsequence
    a_answer_bounded: assert property (setup_s |=> ##[0:3] answer_s)
        else $error("transfer not answered in time");
    a_ready_pulse: assert property (answer_s |=> !pready)
        else $error("ready longer than one cycle");
    a_error_unmapped: assert property (answer_s |-> pslverr == !mapped)
        else $error("error flag does not match address");
    a_pump_follows: assert property (settle > 4'h1 |-> pump_enable == ctl_shadow[0])
        else $error("pump enable differs from control");
    a_bias_follows: assert property (settle > 4'h1 |-> bias_half == ctl_shadow[3])
        else $error("bias select differs from control");
    a_quiet_off: assert property (settle > 4'h5 && !ctl_shadow[5] |->
        common_out == 4'h0 && segment_out == 32'h0 && !frame_clk)
        else $error("driver active while disabled");
    a_common_onehot: assert property ($onehot0(common_out))
        else $error("more than one common active");
    a_common_in_duty: assert property (ctl_shadow[5] |-> (common_out & ~duty_mask) == 4'h0)
        else $error("common outside duty");
    a_pair_data: assert property (held_s |-> segment_out[11:10] == seg_exp)
        else $error("segment level differs from stored bit");
endmodule
bind segment_lcd_driver_control seg_lcd_props props_u (.mclk, .reset_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .prdata, .pslverr, .internal_osc_clk, .external_osc_clk, .segment_out,
    .common_out, .pump_enable, .bias_half, .frame_clk);
`default_nettype wire

// *** sim/lcd_panel_model.sv ***
/* Passive glass panel: keeps the segment levels seen under each common.
   Assumes one-hot commons and a clear strobe from the bench. */
`timescale 1ns/100ps
`default_nettype none
module lcd_panel_model (
    input wire logic         mclk,
    input wire logic         clear,
    input wire logic [31:0]  segment_out,
    input wire logic [3:0]   common_out,
    output logic     [127:0] seen,
    output logic     [3:0]   seen_mask
);
    // ********
    // Electrode sampling
    // ********
    // Last level under each common wins, so driver latency is harmless
    always @(posedge mclk) begin
        if (clear) seen_mask <= 4'h0;
        for (int n = 0; n < 4; n++) begin
            if (!clear && common_out == 4'(1 << n)) begin
                seen[32*n +: 32] <= segment_out;
                seen_mask[n] <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// *** sim/segment_lcd_driver_control_tb_top.sv ***
/* Self-checking bench for the display control block.
   Assumes the design package map and APB answer timing. */
`timescale 1ns/100ps
`default_nettype none
module segment_lcd_driver_control_tb_top;
    logic        mclk, reset_n, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, segment_out;
    logic        internal_osc_clk, external_osc_clk, pump_enable, bias_half, frame_clk, clear;
    logic [3:0]  common_out, seen_mask;
    logic [127:0] seen;
    int          mismatches = 0, check_count = 0, osc_cnt = 0;
    localparam int          TICK = 192;
    localparam logic [11:0] CTL  = {2'h0, seg_lcd_pkg::DISPLAY_CONTROL_IDX, 2'h0};
    localparam logic [11:0] CKS  = {2'h0, seg_lcd_pkg::CLOCK_SELECT_IDX, 2'h0};
    localparam logic [7:0]  P0   = 8'h96;
    localparam logic [7:0]  P5   = 8'hA5;
    // ********
    // Clock, oscillators, instances
    // ********
    always #10 mclk = ~mclk;
    // External period 6 clocks gives a tick every 192 clocks
    always @(posedge mclk) begin
        osc_cnt <= (osc_cnt == 29) ? 0 : osc_cnt + 1;
        if (osc_cnt % 3 == 2) external_osc_clk <= ~external_osc_clk;
        if (osc_cnt % 5 == 4) internal_osc_clk <= ~internal_osc_clk;
    end
    segment_lcd_driver_control dut_u (.mclk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pready, .prdata, .pslverr, .internal_osc_clk, .external_osc_clk, .segment_out,
        .common_out, .pump_enable, .bias_half, .frame_clk);
    lcd_panel_model panel_u (.mclk, .clear, .segment_out, .common_out, .seen, .seen_mask);
    // ********
    // Shared tasks
    // ********
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    // Holds the request until ready, then idles one cycle
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [7:0] wd,
                       input logic [31:0] exp, input logic exp_err);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= {24'h0, wd};
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk);
        while (pready !== 1'b1);
        if (!wr) chk(prdata, exp, "read data");
        chk({31'h0, pslverr}, {31'h0, exp_err}, "error flag");
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic next_rise(output int cyc);
        logic prev;
        cyc = 0;
        do begin
            prev = frame_clk;
            @(posedge mclk);
            cyc++;
        end while (!(prev === 1'b0 && frame_clk === 1'b1) && cyc < 30000);
    endtask
    task automatic off_chk;
        repeat (8) @(posedge mclk);
        chk(segment_out, 32'h0, "segments off");
        chk({27'h0, common_out, frame_clk}, 32'h0, "commons off");
    endtask
    // ********
    // Scenarios
    // ********
    task automatic test_regs;
        logic [7:0] vals [3] = '{8'h01, 8'h08, 8'hD6};
        apb(1'b0, CTL, 8'h00, 32'h0, 1'b0);
        apb(1'b0, CKS, 8'h00, 32'h0, 1'b0);
        foreach (vals[i]) begin
            apb(1'b1, CTL, vals[i], 32'h0, 1'b0);
            apb(1'b0, CTL, 8'h00, {24'h0, vals[i] & 8'hEF}, 1'b0);
            chk({31'h0, pump_enable}, {31'h0, vals[i][0]}, "pump");
            chk({31'h0, bias_half}, {31'h0, vals[i][3]}, "bias");
        end
        apb(1'b1, CKS, 8'hFF, 32'h0, 1'b0);
        apb(1'b0, CKS, 8'h00, 32'h2B, 1'b0);
        apb(1'b1, 12'h1F0, 8'h55, 32'h0, 1'b1);
        apb(1'b0, 12'h1F0, 8'h00, 32'h0, 1'b1);
        apb(1'b0, 12'h151, 8'h00, 32'h0, 1'b1);
        apb(1'b1, 12'h114, P5, 32'h0, 1'b0);
        apb(1'b1, 12'h100, P0, 32'h0, 1'b0);
        apb(1'b1, 12'h124, 8'h3C, 32'h0, 1'b0);
        apb(1'b0, 12'h114, 8'h00, {24'h0, P5}, 1'b0);
        apb(1'b0, 12'h100, 8'h00, {24'h0, P0}, 1'b0);
        apb(1'b0, 12'h124, 8'h00, 32'h3C, 1'b0);
        $display("test registers done");
    endtask
    task automatic test_divider;
        int cyc;
        apb(1'b1, CKS, 8'h20, 32'h0, 1'b0);
        for (int c = 0; c < 4; c++) begin
            apb(1'b1, CTL, {c[1:0], 6'h07}, 32'h0, 1'b0);
            apb(1'b1, CTL, {c[1:0], 6'h27}, 32'h0, 1'b0);
            next_rise(cyc);
            next_rise(cyc);
            chk(cyc, TICK * (8 << c), "frame period");
            apb(1'b1, CTL, 8'h07, 32'h0, 1'b0);
            off_chk();
        end
        $display("test divider done");
    endtask
    task automatic test_scan;
        logic [3:0] mask;
        int cyc;
        for (int d = 3; d >= 0; d--) begin
            mask = (d == 0) ? 4'h1 : 4'((1 << (d + 1)) - 1);
            apb(1'b1, CTL, 8'h09, 32'h0, 1'b0);
            clear <= 1'b1;
            apb(1'b1, CTL, {5'h01, d[1:0], 1'b1}, 32'h0, 1'b0);
            clear <= 1'b0;
            apb(1'b1, CTL, {5'h05, d[1:0], 1'b1}, 32'h0, 1'b0);
            repeat (5) next_rise(cyc);
            chk({28'h0, seen_mask}, {28'h0, mask}, "commons scanned");
            for (int n = 0; n < 4; n++) begin
                if (mask[n]) begin
                    chk({30'h0, seen[32*n+11], seen[32*n+10]}, {30'h0, P5[n+4], P5[n]}, "pair five");
                    chk({30'h0, seen[32*n+1], seen[32*n]}, {30'h0, P0[n+4], P0[n]}, "pair zero");
                end
            end
            apb(1'b1, CTL, 8'h09, 32'h0, 1'b0);
            off_chk();
        end
        $display("test scan done");
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // ********
    // Main sequence and watchdog
    // ********
    initial begin
        mclk = 1'b0;
        reset_n = 1'b0;
        {psel, penable, pwrite, clear, internal_osc_clk, external_osc_clk, paddr, pwdata} = 50'h0;
        repeat (12) @(posedge mclk);
        reset_n <= 1'b1;
        @(posedge mclk);
        test_regs();
        test_divider();
        test_scan();
        close_out();
    end
    // Budget about 100k clocks; the tests need roughly 62k
    initial begin
        #2000000;
        mismatches++;
        $display("MISMATCH at %0t: watchdog expired", $time);
        close_out();
    end
endmodule
`default_nettype wire
